// ---- rtl/lpms_pkg.sv ----
// lpms_pkg: shared constants and types of the low power mode sequencer
// assumes a single 10 MHz ref_clk domain and plain control ports
package lpms_pkg;
	localparam int unsigned CLK_HZ = 10000000;
	// reset stretch after supply recovery or wakeup, in ns
	localparam int unsigned RESET_HOLD_NS = 2000;
	localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [7:0] RESET_HOLD_CNT = RESET_HOLD_CYC[7:0];
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam int unsigned EDGE_LINES = 16;
	localparam int unsigned WAKE_SRC = EDGE_LINES + 2;
	// regulator mode encodings on reg_mode
	localparam logic [1:0] REG_MAIN = 2'h0;
	localparam logic [1:0] REG_LOWPOWER = 2'h1;
	localparam logic [1:0] REG_POWERDOWN = 2'h2;
	// monitor trigger selection bits
	localparam int unsigned TRIG_FALL_BIT = 0;
	localparam int unsigned TRIG_RISE_BIT = 1;
	typedef enum logic [2:0] {
		LPMS_RESET,
		LPMS_RUN,
		LPMS_SLEEP,
		LPMS_STOP,
		LPMS_STANDBY
	} lpms_state_t;
endpackage

// ---- rtl/lpms_edge.sv ----
// lpms_edge: rising and falling edge detector for a vector of lines, against a registered previous sample
// assumes inputs synchronous to ref_clk
module lpms_edge
	import lpms_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [W-1:0] level_in, // lines to watch
	output logic [W-1:0] rise, // one-cycle rising pulse
	output logic [W-1:0] fall // one-cycle falling pulse
);
	logic [W-1:0] prev;
	logic [W-1:0] next_prev;

	// previous sample
	always_comb begin
		next_prev = level_in;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prev <= '0;
		end else begin
			prev <= next_prev;
		end
	end

	// combinational pulses, one cycle wide
	assign rise = level_in & ~prev;
	assign fall = ~level_in & prev;
endmodule

// ---- rtl/lpms_sequencer.sv ----
// lpms_sequencer: supply supervision, regulator mode and low-power mode sequencing
// assumes all inputs synchronous to ref_clk; analog comparators outside give levels
module lpms_sequencer
	import lpms_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic supply_below_reset, // supply under reset threshold
	input wire logic supply_below_monitor, // supply under monitor threshold
	input wire logic monitor_enable, // software enable of monitor
	input wire logic [1:0] monitor_trigger, // bit0 fall, bit1 rise
	input wire logic stop_lowpower_sel, // regulator low-power in stop
	input wire logic sleep_request, // processor asks for sleep
	input wire logic deep_request, // processor asks for stop/standby
	input wire logic standby_select, // deep request means standby
	input wire logic periph_event, // any peripheral interrupt or event
	input wire logic [EDGE_LINES-1:0] edge_wake_lines, // external edge lines
	input wire logic rtc_alarm, // RTC alarm pulse or level
	input wire logic wake_pin, // wake pin level
	input wire logic external_reset_pin_n, // external reset pin, active low
	input wire logic watchdog_reset, // independent watchdog reset request
	output logic system_reset_n, // device reset, active low
	output logic monitor_irq, // monitor interrupt request pulse
	output logic monitor_out, // monitor comparator output
	output logic [1:0] reg_mode, // regulator mode
	output logic reg_enable, // regulator enabled
	output logic reg_out_en, // regulator output driven
	output logic cpu_clk_en, // processor clock enable
	output logic core_clk_en, // core domain clocks enable
	output logic periph_clk_en, // peripheral clocks enable
	output logic pll_en, // PLL enable
	output logic internal_fast_rc_en, // internal fast RC enable
	output logic external_fast_osc_en, // external fast oscillator enable
	output logic default_clk_sel, // default clock forced
	output logic core_power_en, // core domain powered
	output logic state_retained, // SRAM and registers retained
	output logic lowspeed_keep_en, // RTC/watchdog and their clocks on
	output logic standby_flag // woke from standby, cleared by reset
);
	lpms_state_t state, next_state;
	logic [7:0] hold_cnt, next_hold_cnt;
	logic standby_wake, next_standby_wake;
	logic irq, next_irq;
	logic [1:0] mode, next_mode;
	// positions of the monitor and wake pin in the shared detector vector
	localparam int unsigned MON_POS = EDGE_LINES;
	localparam int unsigned WAKE_POS = EDGE_LINES + 1;
	logic [WAKE_SRC-1:0] edge_rise;
	logic [WAKE_SRC-1:0] edge_fall;
	logic [EDGE_LINES-1:0] line_rise;
	logic mon_rise;
	logic mon_fall;
	logic wake_rise;
	logic stop_wake;
	logic standby_exit;

	// one edge detector covers the lines, the ungated supply_below_monitor level and the wake pin
	lpms_edge #(.W(WAKE_SRC)) u_edge (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.level_in({wake_pin, supply_below_monitor, edge_wake_lines}),
		.rise(edge_rise),
		.fall(edge_fall)
	);

	// split the detector vector; only the monitor needs its falling edge
	assign line_rise = edge_rise[EDGE_LINES-1:0];
	assign mon_rise = edge_rise[MON_POS];
	assign mon_fall = edge_fall[MON_POS];
	assign wake_rise = edge_rise[WAKE_POS];

	// monitor output: falling supply means comparator output rising
	assign monitor_out = monitor_enable & supply_below_monitor;
	// either monitor crossing is an edge line, so both wake stop when enabled
	assign stop_wake = (|line_rise) | (monitor_enable & (mon_rise | mon_fall)) | rtc_alarm;
	// reset pin is a level here, honoured only in standby and the reset stretch
	assign standby_exit = !external_reset_pin_n | watchdog_reset | wake_rise | rtc_alarm;

	// state sequencing; reset counter stretches release
	always_comb begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		next_standby_wake = standby_wake;
		case (state)
			LPMS_RESET: begin
				// supply low keeps counter reloaded, so reset never releases
				if (supply_below_reset || !external_reset_pin_n) begin
					next_hold_cnt = RESET_HOLD_CNT;
				end else if (hold_cnt > CNT_ONE) begin
					next_hold_cnt = hold_cnt - CNT_ONE;
				end else begin
					next_hold_cnt = CNT_ZERO;
					next_state = LPMS_RUN;
				end
			end
			LPMS_RUN: begin
				next_standby_wake = standby_wake;
				// sleep wins when both requests are up
				if (sleep_request) begin
					next_state = LPMS_SLEEP;
				end else if (deep_request && standby_select) begin
					next_state = LPMS_STANDBY;
				end else if (deep_request) begin
					next_state = LPMS_STOP;
				end
			end
			LPMS_SLEEP: begin
				if (periph_event) begin
					next_state = LPMS_RUN;
				end
			end
			LPMS_STOP: begin
				if (stop_wake) begin
					next_state = LPMS_RUN;
				end
			end
			LPMS_STANDBY: begin
				// state is gone, so restart through the reset stretch
				if (standby_exit) begin
					next_state = LPMS_RESET;
					next_hold_cnt = RESET_HOLD_CNT;
					next_standby_wake = 1'b1;
				end
			end
			default: begin
				next_state = LPMS_RESET;
				next_hold_cnt = RESET_HOLD_CNT;
			end
		endcase
		// supply collapse overrides every mode
		if (supply_below_reset) begin
			next_state = LPMS_RESET;
			next_hold_cnt = RESET_HOLD_CNT;
			next_standby_wake = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= LPMS_RESET;
			hold_cnt <= RESET_HOLD_CNT;
			standby_wake <= 1'b0;
		end else begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
			standby_wake <= next_standby_wake;
		end
	end

	// monitor interrupt on selected crossings, only while enabled
	always_comb begin
		next_irq = monitor_enable & ((monitor_trigger[TRIG_FALL_BIT] & mon_rise)
			| (monitor_trigger[TRIG_RISE_BIT] & mon_fall));
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// regulator mode per state
	always_comb begin
		case (next_state)
			LPMS_STOP: next_mode = stop_lowpower_sel ? REG_LOWPOWER : REG_MAIN;
			LPMS_STANDBY: next_mode = REG_POWERDOWN;
			default: next_mode = REG_MAIN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode <= REG_MAIN;
		end else begin
			mode <= next_mode;
		end
	end

	// run and sleep keep the fast clock tree alive
	function automatic logic clocks_running(input lpms_state_t s);
		return (s == LPMS_RUN) || (s == LPMS_SLEEP);
	endfunction

	// the regulator drives its output in every mode except power-down
	function automatic logic regulator_on(input logic [1:0] m);
		return m != REG_POWERDOWN;
	endfunction

	// outputs decoded from registered state
	assign system_reset_n = (state != LPMS_RESET) && (state != LPMS_STANDBY);
	assign monitor_irq = irq;
	assign reg_mode = mode;
	assign reg_enable = regulator_on(mode);
	assign reg_out_en = regulator_on(mode);
	assign cpu_clk_en = (state == LPMS_RUN);
	assign periph_clk_en = clocks_running(state);
	assign core_clk_en = clocks_running(state) || (state == LPMS_RESET);
	assign pll_en = clocks_running(state);
	// fast RC also runs during reset since it is the default clock
	assign internal_fast_rc_en = (state != LPMS_STOP) && (state != LPMS_STANDBY);
	assign external_fast_osc_en = clocks_running(state);
	assign default_clk_sel = (state == LPMS_RESET);
	assign core_power_en = (state != LPMS_STANDBY);
	assign state_retained = (state != LPMS_STANDBY);
	assign lowspeed_keep_en = 1'b1;
	assign standby_flag = standby_wake;
endmodule

// ---- bench/lpms_monitor.sv ----
// lpms_monitor: port-level properties of the sequencer
// assumes a bind onto lpms_sequencer, one clock, sync reset
module lpms_monitor
	import lpms_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic rst_n, // sync reset
	input wire logic supply_below_reset, // low supply
	input wire logic supply_below_monitor, // under threshold
	input wire logic monitor_enable, // monitor on
	input wire logic [1:0] monitor_trigger, // edge select
	input wire logic stop_lowpower_sel, // stop regulator
	input wire logic periph_event, // sleep wake
	input wire logic [EDGE_LINES-1:0] edge_wake_lines, // stop wake
	input wire logic rtc_alarm, // alarm
	input wire logic wake_pin, // wake pin
	input wire logic watchdog_reset, // watchdog
	input wire logic system_reset_n, // device reset
	input wire logic monitor_irq, // irq pulse
	input wire logic [1:0] reg_mode, // regulator mode
	input wire logic reg_enable, // regulator on
	input wire logic cpu_clk_en, // cpu clock
	input wire logic periph_clk_en, // periph clocks
	input wire logic core_clk_en, // core clocks
	input wire logic core_power_en, // core powered
	input wire logic state_retained, // retention
	input wire logic default_clk_sel, // default clock
	input wire logic standby_flag // standby wake flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// states decoded from outputs, so a wrong decode shows too
	wire in_stop = !core_clk_en && core_power_en;
	wire in_sleep = !cpu_clk_en && periph_clk_en;
	property p_por; supply_below_reset |=> !system_reset_n; endproperty
	a_por: assert property (p_por) else $error("reset not held");
	property p_irq;
		monitor_enable && monitor_trigger[0] && $rose(supply_below_monitor) |=> monitor_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("no monitor irq");
	property p_pdown; (reg_mode == REG_POWERDOWN) == !reg_enable && reg_enable == core_power_en; endproperty
	a_pdown: assert property (p_pdown) else $error("regulator mode wrong");
	property p_sleep; in_sleep && periph_event |=> cpu_clk_en; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not woken");
	property p_stop;
		in_stop |-> state_retained && reg_mode == ($past(stop_lowpower_sel) ? REG_LOWPOWER : REG_MAIN);
	endproperty
	a_stop: assert property (p_stop) else $error("stop state wrong");
	property p_stopwake; in_stop && |(edge_wake_lines & ~$past(edge_wake_lines)) |-> ##[1:2] cpu_clk_en; endproperty
	a_stopwake: assert property (p_stopwake) else $error("stop not woken");
	property p_sbpin;
		!core_power_en && $rose(wake_pin) |-> ##[1:2] core_power_en && !system_reset_n && default_clk_sel && standby_flag;
	endproperty
	a_sbpin: assert property (p_sbpin) else $error("wake pin ignored");
	property p_sbexit; !core_power_en && (watchdog_reset || rtc_alarm) |=> core_power_en && reg_enable; endproperty
	a_sbexit: assert property (p_sbexit) else $error("standby not left");
	cover property (monitor_irq);
	cover property (in_stop ##1 cpu_clk_en);
	cover property (!core_power_en ##1 core_power_en);
endmodule
bind lpms_sequencer lpms_monitor u_mon (
	.ref_clk(ref_clk), .rst_n(rst_n), .supply_below_reset(supply_below_reset),
	.supply_below_monitor(supply_below_monitor), .monitor_enable(monitor_enable),
	.monitor_trigger(monitor_trigger), .stop_lowpower_sel(stop_lowpower_sel),
	.periph_event(periph_event), .edge_wake_lines(edge_wake_lines),
	.rtc_alarm(rtc_alarm), .wake_pin(wake_pin), .watchdog_reset(watchdog_reset),
	.system_reset_n(system_reset_n), .monitor_irq(monitor_irq), .reg_mode(reg_mode),
	.reg_enable(reg_enable), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
	.core_clk_en(core_clk_en), .core_power_en(core_power_en),
	.state_retained(state_retained), .default_clk_sel(default_clk_sel),
	.standby_flag(standby_flag)
);

// ---- bench/lpms_sequencer_tb_top.sv ----
// lpms_sequencer_tb_top: directed self-checking bench for the sequencer
// assumes lpms_monitor is bound onto the design
module lpms_sequencer_tb_top import lpms_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, supply_below_reset = 0, supply_below_monitor = 0;
	logic monitor_enable = 0, stop_lowpower_sel = 0, sleep_request = 0, deep_request = 0;
	logic standby_select = 0, periph_event = 0, rtc_alarm = 0, wake_pin = 0;
	logic external_reset_pin_n = 1, watchdog_reset = 0;
	logic [1:0] monitor_trigger = 2'h0;
	logic [EDGE_LINES-1:0] edge_wake_lines = 16'h0000;
	logic system_reset_n, monitor_irq, monitor_out, reg_enable, reg_out_en, cpu_clk_en;
	logic core_clk_en, periph_clk_en, pll_en, internal_fast_rc_en, external_fast_osc_en;
	logic default_clk_sel, core_power_en, state_retained, lowspeed_keep_en, standby_flag;
	logic [1:0] reg_mode;
	int mismatches = 0, samples_checked = 0;
	lpms_sequencer uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .supply_below_reset(supply_below_reset),
		.supply_below_monitor(supply_below_monitor), .monitor_enable(monitor_enable),
		.monitor_trigger(monitor_trigger), .stop_lowpower_sel(stop_lowpower_sel),
		.sleep_request(sleep_request), .deep_request(deep_request),
		.standby_select(standby_select), .periph_event(periph_event),
		.edge_wake_lines(edge_wake_lines), .rtc_alarm(rtc_alarm), .wake_pin(wake_pin),
		.external_reset_pin_n(external_reset_pin_n), .watchdog_reset(watchdog_reset),
		.system_reset_n(system_reset_n), .monitor_irq(monitor_irq),
		.monitor_out(monitor_out), .reg_mode(reg_mode), .reg_enable(reg_enable),
		.reg_out_en(reg_out_en), .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en),
		.periph_clk_en(periph_clk_en), .pll_en(pll_en),
		.internal_fast_rc_en(internal_fast_rc_en),
		.external_fast_osc_en(external_fast_osc_en), .default_clk_sel(default_clk_sel),
		.core_power_en(core_power_en), .state_retained(state_retained),
		.lowspeed_keep_en(lowspeed_keep_en), .standby_flag(standby_flag)
	);
	always #50 ref_clk = ~ref_clk;
	task cyc(input int n = 1);
		repeat (n) @(posedge ref_clk);
	endtask
	task chk(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// bounded wait for the reset stretch to end
	task wait_run;
		int n;
		n = 0;
		while (system_reset_n !== 1'b1 && n < 200) begin
			cyc();
			#1;
			n++;
		end
		chk({n < 200, cpu_clk_en, lowspeed_keep_en, reg_enable}, 4'hF);
	endtask
	// low supply held past the stretch must keep reset and clear the standby flag
	task t_por;
		cyc();
		supply_below_reset <= 1'b1;
		cyc(30);
		supply_below_reset <= 1'b0;
		#1;
		chk({system_reset_n, default_clk_sel, standby_flag}, 4'h2);
		wait_run();
	endtask
	task t_irq;
		cyc();
		monitor_enable <= 1'b1;
		monitor_trigger <= 2'h1;
		cyc();
		supply_below_monitor <= 1'b1;
		cyc();
		#1;
		chk({monitor_irq, monitor_out}, 4'h3);
		cyc();
		monitor_trigger <= 2'h2;
		supply_below_monitor <= 1'b0;
		cyc();
		#1;
		chk(monitor_irq, 1'b1);
		cyc();
		#1;
		chk(monitor_irq, 1'b0);
	endtask
	task t_sleep;
		cyc();
		sleep_request <= 1'b1;
		cyc();
		sleep_request <= 1'b0;
		#1;
		chk({cpu_clk_en, periph_clk_en, pll_en, state_retained}, 4'h7);
		cyc();
		periph_event <= 1'b1;
		cyc();
		periph_event <= 1'b0;
		#1;
		chk(cpu_clk_en, 1'b1);
	endtask
	// src 0 top line, 1 bottom line, 2 alarm, 3 monitor crossing; bit0 picks regulator
	task t_stop(input int src);
		cyc();
		stop_lowpower_sel <= src[0];
		deep_request <= 1'b1;
		cyc();
		deep_request <= 1'b0;
		#1;
		chk({core_clk_en, pll_en, state_retained, internal_fast_rc_en}, 4'h2);
		chk({external_fast_osc_en, lowspeed_keep_en, reg_mode},
			{2'h1, src[0] ? REG_LOWPOWER : REG_MAIN});
		cyc();
		edge_wake_lines <= (src < 2) ? 16'h8000 >> (src * 15) : 16'h0000;
		rtc_alarm <= (src == 2);
		supply_below_monitor <= (src == 3);
		cyc(2);
		edge_wake_lines <= 16'h0000;
		rtc_alarm <= 1'b0;
		supply_below_monitor <= 1'b0;
		#1;
		chk(cpu_clk_en, 1'b1);
	endtask
	// src 0 wake pin, 1 watchdog, 2 alarm, 3 reset pin
	task t_standby(input int src);
		cyc();
		standby_select <= 1'b1;
		deep_request <= 1'b1;
		cyc();
		deep_request <= 1'b0;
		standby_select <= 1'b0;
		#1;
		chk({reg_mode, reg_enable, core_power_en}, 4'h8);
		chk({reg_out_en, pll_en, system_reset_n, lowspeed_keep_en}, 4'h1);
		cyc(3);
		{wake_pin, watchdog_reset, rtc_alarm} <= 3'h4 >> src;
		external_reset_pin_n <= (src != 3);
		cyc(2);
		{wake_pin, watchdog_reset, rtc_alarm} <= 3'h0;
		external_reset_pin_n <= 1'b1;
		#1;
		chk({core_power_en, reg_enable, default_clk_sel, standby_flag}, 4'hF);
		wait_run();
	endtask
	initial begin
		cyc(8);
		rst_n <= 1'b1;
		wait_run();
		t_irq();
		t_sleep();
		for (int i = 0; i < 4; i++) t_stop(i);
		for (int i = 0; i < 4; i++) t_standby(i);
		t_por();
		conclude();
	end
	// watchdog: the sequence needs well under 10000 cycles
	initial begin
		#1000000;
		mismatches++;
		conclude();
	end
endmodule
